//--- ppt_host.sv
// host controller model: table memory writes and network commands
module ppt_host (
  input  wire logic         i_sys_clk,
  output ppt_pkg::ppt_wr_t  o_wr,
  output ppt_pkg::ppt_cmd_t o_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  // nothing requested at time zero
  initial begin
    o_wr  = '0;
    o_cmd = '0;
  end

  // one 32-bit field word; idle bus shows the inverse word
  task automatic wr(input logic [2:0] idx, input logic [2:0] fld,
                    input logic [31:0] data);
    @(posedge i_sys_clk);
    o_wr <= '{valid: 1'b1, idx: idx, field: fld, data: data};
    @(posedge i_sys_clk);
    o_wr <= '{valid: 1'b0, idx: ~idx, field: ~fld, data: ~data};
  endtask : wr

  // one command strobe, idle code inverted
  task automatic cmd(input logic [7:0] code, input logic reference_established_flag);
    @(posedge i_sys_clk);
    o_cmd <= '{valid: 1'b1, code: code, reference_established_flag: reference_established_flag};
    @(posedge i_sys_clk);
    o_cmd <= '{valid: 1'b0, code: ~code, reference_established_flag: ~reference_established_flag};
  endtask : cmd

  // whole entry, compare position first
  task automatic load(input logic [2:0] idx, input logic [31:0] p,
                      input logic [31:0] fn, input logic [31:0] tm,
                      input logic [31:0] ds, input logic [31:0] cp);
    wr(idx, ppt_pkg::FLD_POS, p);
    wr(idx, ppt_pkg::FLD_FUNC, fn);
    wr(idx, ppt_pkg::FLD_TIME, tm);
    wr(idx, ppt_pkg::FLD_DIST, ds);
    wr(idx, ppt_pkg::FLD_COMP, cp);
  endtask : load
endmodule : ppt_host

//--- ppt_pkg.sv
// shared constants and carrier types for the preset position trigger block
package ppt_pkg;
  // table geometry: entries 0..3 fast path, 4..7 photocoupler path
  localparam int          N_PATH        = 4;
  localparam int          N_ENT         = 8;
  localparam int          IDX_W         = 3;
  localparam int          N_FAST_TERM   = 2;
  localparam int          N_NORM_TERM   = 3;
  // host command codes
  localparam logic [7:0]  CMD_SENSOR_ON = 8'h23;
  localparam logic [7:0]  CMD_ZERO_RET  = 8'h3A;
  localparam logic [7:0]  CMD_SET_COORD = 8'h20;
  localparam logic [7:0]  CMD_SETUP_DEV = 8'h04;
  // field selectors inside one table entry (word index)
  localparam logic [2:0]  FLD_POS       = 3'h0;
  localparam logic [2:0]  FLD_FUNC      = 3'h1;
  localparam logic [2:0]  FLD_TIME      = 3'h2;
  localparam logic [2:0]  FLD_DIST      = 3'h3;
  localparam logic [2:0]  FLD_COMP      = 3'h4;
  // output function digit positions
  localparam int          FN_AXIS_LSB   = 0;
  localparam int          FN_TERM_LSB   = 4;
  localparam int          FN_DIR_LSB    = 8;
  // passing direction codes
  localparam logic [3:0]  DIR_FWD       = 4'h0;
  localparam logic [3:0]  DIR_REV       = 4'h1;
  localparam logic [3:0]  DIR_BOTH      = 4'h2;
  // terminal codes, fast path
  localparam logic [3:0]  FT_T0         = 4'h1;
  localparam logic [3:0]  FT_T1         = 4'h2;
  localparam logic [3:0]  FT_T0_INV     = 4'h3;
  localparam logic [3:0]  FT_T1_INV     = 4'h4;
  // terminal codes, photocoupler path: plain base, inverted base
  localparam logic [3:0]  NT_BASE       = 4'h1;
  localparam logic [3:0]  NT_INV_BASE   = 4'h6;
  // width mode digit values
  localparam logic        WM_TIME       = 1'b0;
  localparam logic        WM_DIST       = 1'b1;
  // timing: 8 ns clock, 1 us and 1 ms width units
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          T_US_NS       = 1000;
  localparam int          T_MS_US       = 1000;
  localparam int          US_CYC        = T_US_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  US_CNT_RST    = 8'h00;
  localparam logic [9:0]  MS_CNT_RST    = 10'h000;

  typedef struct packed {
    logic [31:0] pos;
    logic [31:0] func;
    logic [31:0] width_time;
    logic [31:0] width_dist;
    logic [31:0] comp;
  } ppt_entry_t;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] idx;
    logic [2:0]       field;
    logic [31:0]      data;
  } ppt_wr_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic       reference_established_flag;
  } ppt_cmd_t;

  localparam ppt_entry_t ENTRY_RST = '0;
endpackage : ppt_pkg

//--- ppt_tick_gen.sv
// microsecond and millisecond enable pulses from the system clock
module ppt_tick_gen (
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  output logic      o_us_tick,
  output logic      o_ms_tick
);
  logic [7:0] us_cnt_r;
  logic [7:0] us_cnt_nxt;
  logic [9:0] ms_cnt_r;
  logic [9:0] ms_cnt_nxt;
  logic       us_end;
  logic       ms_end;

  // divider terminal counts
  assign us_end    = (us_cnt_r == 8'(ppt_pkg::US_CYC - 1));
  assign ms_end    = (ms_cnt_r == 10'(ppt_pkg::T_MS_US - 1));
  assign o_us_tick = us_end;
  assign o_ms_tick = us_end && ms_end;

  // next counter values
  always_comb begin
    us_cnt_nxt = us_end ? ppt_pkg::US_CNT_RST : us_cnt_r + 8'h01;
    ms_cnt_nxt = ms_cnt_r;
    if (us_end) begin
      ms_cnt_nxt = ms_end ? ppt_pkg::MS_CNT_RST : ms_cnt_r + 10'h001;
    end
  end

  // counter registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      us_cnt_r <= ppt_pkg::US_CNT_RST;
      ms_cnt_r <= ppt_pkg::MS_CNT_RST;
    end else begin
      us_cnt_r <= us_cnt_nxt;
      ms_cnt_r <= ms_cnt_nxt;
    end
  end
endmodule : ppt_tick_gen

//--- ppt_trigger.sv
// preset position trigger: table, commit, crossing detect, width, outputs
module ppt_trigger (
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset_n,
  input  wire ppt_pkg::ppt_wr_t  i_tbl_wr,
  input  wire ppt_pkg::ppt_cmd_t i_cmd,
  input  wire logic              i_width_mode_param,
  input  wire logic              i_incremental_enc,
  input  wire logic              i_servo_on,
  input  wire logic [31:0]       i_position,
  output logic [1:0]             o_fast_trig,
  output logic [2:0]             o_norm_trig,
  output logic                   o_sensor_on,
  output logic                   o_reference_established_flag,
  output logic                   o_armed
);
  localparam int NE = ppt_pkg::N_ENT;
  localparam int NP = ppt_pkg::N_PATH;

  ppt_pkg::ppt_entry_t shadow_r [NE];
  ppt_pkg::ppt_entry_t shadow_nxt [NE];
  ppt_pkg::ppt_entry_t active_r [NE];
  ppt_pkg::ppt_entry_t active_nxt [NE];
  logic                sensor_on_r;
  logic                sensor_on_nxt;
  logic                reference_established_flag_r;
  logic                reference_established_flag_nxt;
  logic signed [31:0]  prev_pos_r;
  logic signed [31:0]  cur_pos;
  logic signed [31:0]  delta;
  logic [31:0]         travel;
  logic [NE-1:0]       act_r;
  logic [NE-1:0]       act_nxt;
  logic [NE-1:0]       hit;
  logic [NE-1:0]       fwd_x;
  logic [NE-1:0]       rev_x;
  logic [31:0]         rem_r [NE];
  logic [31:0]         rem_nxt [NE];
  logic [1:0]          fast_nxt;
  logic [2:0]          norm_nxt;
  logic [1:0]          fast_r;
  logic [2:0]          norm_r;
  logic                us_tick;
  logic                ms_tick;
  logic                cmd_setup;
  logic                armed;

  ppt_tick_gen u_tick (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .o_us_tick (us_tick),
    .o_ms_tick (ms_tick)
  );

  assign cmd_setup = i_cmd.valid && (i_cmd.code == ppt_pkg::CMD_SETUP_DEV);
  assign cur_pos   = i_position;
  assign delta     = cur_pos - prev_pos_r;
  assign travel    = delta[31] ? 32'(-delta) : 32'(delta);

  // triggers run only with sensor on, servo on and, for an incremental encoder, reference known
  assign armed = sensor_on_r && i_servo_on &&
                 (reference_established_flag_r || !i_incremental_enc);

  // table shadow writes, commit, sensor and reference state
  always_comb begin
    shadow_nxt    = shadow_r;
    active_nxt    = active_r;
    sensor_on_nxt = sensor_on_r;
    reference_established_flag_nxt      = reference_established_flag_r;
    if (i_tbl_wr.valid) begin
      case (i_tbl_wr.field)
        ppt_pkg::FLD_POS:  shadow_nxt[i_tbl_wr.idx].pos = i_tbl_wr.data;
        ppt_pkg::FLD_FUNC: shadow_nxt[i_tbl_wr.idx].func = i_tbl_wr.data;
        ppt_pkg::FLD_TIME: shadow_nxt[i_tbl_wr.idx].width_time = i_tbl_wr.data;
        ppt_pkg::FLD_DIST: shadow_nxt[i_tbl_wr.idx].width_dist = i_tbl_wr.data;
        ppt_pkg::FLD_COMP: shadow_nxt[i_tbl_wr.idx].comp = i_tbl_wr.data;
        default: ;
      endcase
    end
    if (cmd_setup) begin
      active_nxt = shadow_r;
    end
    if (i_cmd.valid && (i_cmd.code == ppt_pkg::CMD_SENSOR_ON)) begin
      sensor_on_nxt = 1'b1;
    end
    if (i_cmd.valid && (i_cmd.code == ppt_pkg::CMD_ZERO_RET)) begin
      reference_established_flag_nxt = 1'b1;
    end
    if (i_cmd.valid && (i_cmd.code == ppt_pkg::CMD_SET_COORD)) begin
      reference_established_flag_nxt = i_cmd.reference_established_flag;
    end
  end

  // control state registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      for (int k = 0; k < NE; k++) begin
        shadow_r[k] <= ppt_pkg::ENTRY_RST;
        active_r[k] <= ppt_pkg::ENTRY_RST;
      end
      sensor_on_r <= 1'b0;
      reference_established_flag_r      <= 1'b0;
      prev_pos_r  <= '0;
    end else begin
      shadow_r    <= shadow_nxt;
      active_r    <= active_nxt;
      sensor_on_r <= sensor_on_nxt;
      reference_established_flag_r      <= reference_established_flag_nxt;
      prev_pos_r  <= cur_pos; // sampled for crossing detect and distance-mode travel
    end
  end

  // per entry crossing detect and width bookkeeping
  for (genvar g = 0; g < NE; g++) begin : g_ent
    logic signed [31:0] target;
    logic [3:0]         dir;
    logic [3:0]         term;
    logic [3:0]         axis;
    logic [31:0]        width;
    logic               tick;

    assign target = active_r[g].pos + active_r[g].comp;
    assign dir    = active_r[g].func[ppt_pkg::FN_DIR_LSB +: 4];
    assign term   = active_r[g].func[ppt_pkg::FN_TERM_LSB +: 4];
    assign axis   = active_r[g].func[ppt_pkg::FN_AXIS_LSB +: 4];
    assign width  = (i_width_mode_param == ppt_pkg::WM_DIST) ?
                    active_r[g].width_dist : active_r[g].width_time;
    assign tick   = (g >= NP) ? ms_tick : us_tick;
    assign fwd_x[g] = (prev_pos_r < target) && (cur_pos >= target);
    assign rev_x[g] = (prev_pos_r > target) && (cur_pos <= target);
    assign hit[g] = armed && (axis == 4'h0) && (term != 4'h0) &&
                    (((dir == ppt_pkg::DIR_FWD) && fwd_x[g]) ||
                     ((dir == ppt_pkg::DIR_REV) && rev_x[g]) ||
                     ((dir == ppt_pkg::DIR_BOTH) &&
                      (fwd_x[g] || rev_x[g])));

    // fire, then count the width down in the selected unit
    always_comb begin
      act_nxt[g] = act_r[g];
      rem_nxt[g] = rem_r[g];
      if (hit[g] && (width != 32'h0)) begin
        act_nxt[g] = 1'b1;
        rem_nxt[g] = width;
      end else if (act_r[g]) begin
        if (i_width_mode_param == ppt_pkg::WM_DIST) begin
          if (travel >= rem_r[g]) begin
            act_nxt[g] = 1'b0;
            rem_nxt[g] = 32'h0;
          end else begin
            rem_nxt[g] = rem_r[g] - travel;
          end
        end else if (tick) begin
          act_nxt[g] = (rem_r[g] > 32'h1);
          rem_nxt[g] = rem_r[g] - 32'h1;
        end
      end
    end

    // entry pulse registers
    always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
        act_r[g] <= 1'b0;
        rem_r[g] <= 32'h0;
      end else begin
        act_r[g] <= act_nxt[g];
        rem_r[g] <= rem_nxt[g];
      end
    end
  end

  // terminal merge; descending scan so the lowest entry sets polarity
  always_comb begin
    logic [1:0] f_any;
    logic [1:0] f_inv;
    logic [2:0] n_any;
    logic [2:0] n_inv;
    logic [3:0] tc;
    f_any = '0;
    f_inv = '0;
    n_any = '0;
    n_inv = '0;
    tc    = '0;
    for (int k = NP - 1; k >= 0; k--) begin
      tc = active_r[k].func[ppt_pkg::FN_TERM_LSB +: 4];
      for (int t = 0; t < ppt_pkg::N_FAST_TERM; t++) begin
        if (tc == ppt_pkg::FT_T0 + 4'(t)) begin
          f_any[t] = f_any[t] | act_r[k];
          f_inv[t] = 1'b0;
        end else if (tc == ppt_pkg::FT_T0_INV + 4'(t)) begin
          f_any[t] = f_any[t] | act_r[k];
          f_inv[t] = 1'b1;
        end
      end
    end
    for (int k = NE - 1; k >= NP; k--) begin
      tc = active_r[k].func[ppt_pkg::FN_TERM_LSB +: 4];
      for (int t = 0; t < ppt_pkg::N_NORM_TERM; t++) begin
        if (tc == ppt_pkg::NT_BASE + 4'(t)) begin
          n_any[t] = n_any[t] | act_r[k];
          n_inv[t] = 1'b0;
        end else if (tc == ppt_pkg::NT_INV_BASE + 4'(t)) begin
          n_any[t] = n_any[t] | act_r[k];
          n_inv[t] = 1'b1;
        end
      end
    end
    fast_nxt = f_any ^ f_inv;
    norm_nxt = n_any ^ n_inv;
  end

  // registered terminal outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      fast_r <= '0;
      norm_r <= '0;
    end else begin
      fast_r <= fast_nxt;
      norm_r <= norm_nxt;
    end
  end

  assign o_fast_trig                  = fast_r;
  assign o_norm_trig                  = norm_r;
  assign o_sensor_on                  = sensor_on_r;
  assign o_reference_established_flag = reference_established_flag_r;
  assign o_armed                      = armed;

  // checks
  a_no_early_use: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !cmd_setup |=> active_r[0] == $past(active_r[0]))
    else $error("fast entry changed without setup");
  a_setup_apply: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    cmd_setup |=> active_r[NP] == $past(shadow_r[NP]))
    else $error("setup did not apply shadow");
  a_sensor_start: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_cmd.valid && i_cmd.code == ppt_pkg::CMD_SENSOR_ON) |=> sensor_on_r)
    else $error("sensor on not taken");
  a_ref_needed: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_incremental_enc && !reference_established_flag_r) |-> hit == '0)
    else $error("fired without reference");
  a_fast_fire: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (hit[0] && rem_nxt[0] != 32'h0) |=> act_r[0] ##1 fast_r != 2'b00 ||
      active_r[0].func[ppt_pkg::FN_TERM_LSB +: 4] > ppt_pkg::FT_T1)
    else $error("fast trigger not asserted");
  a_norm_fire: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (hit[NP] && rem_nxt[NP] != 32'h0) |=> act_r[NP])
    else $error("photocoupler trigger not asserted");
  a_dir_select: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (hit[0] && active_r[0].func[ppt_pkg::FN_DIR_LSB +: 4] == ppt_pkg::DIR_REV)
      |-> rev_x[0] && delta <= 0)
    else $error("reverse entry fired moving forward");
  a_ms_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (act_r[NP] && !i_width_mode_param && !ms_tick && !hit[NP])
      |=> rem_r[NP] == $past(rem_r[NP]))
    else $error("photocoupler time moved off ms tick");
  a_us_end: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (act_r[0] && !i_width_mode_param && us_tick && rem_r[0] == 32'h1 &&
     !hit[0]) |=> !act_r[0])
    else $error("fast pulse overran its time");
  a_low_polarity: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (active_r[0].func[ppt_pkg::FN_TERM_LSB +: 4] == ppt_pkg::FT_T0_INV &&
     act_r[NP-1:0] == '0) |=> fast_r[0])
    else $error("lowest entry polarity not used");
  c_fast_pulse: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !fast_r[0] ##1 fast_r[0] ##[1:300] !fast_r[0]);
  c_norm_pulse: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !norm_r[0] ##1 norm_r[0]);
  c_dist_end: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_width_mode_param && act_r[0] ##1 !act_r[0]);
endmodule : ppt_trigger

//--- ppt_trigger_test.sv
// self-checking bench for the preset position trigger block
module ppt_trigger_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  i_sys_clk;
  logic                  i_reset_n;
  logic                  wm;
  logic                  inc;
  logic                  servo;
  logic [31:0]           pos;
  logic [31:0]           p_nom;
  logic [31:0]           comp;
  logic [31:0]           tgt;
  logic [31:0]           seed;
  int                    err_total;
  int                    compares;
  ppt_pkg::ppt_wr_t      tbl_wr;
  ppt_pkg::ppt_cmd_t     cmd;
  logic [1:0]            fast;
  logic [2:0]            norm;
  logic                  sens;
  logic                  reference_established_flag;
  logic                  armed;

  // host side model
  ppt_host i_host (
    .i_sys_clk (i_sys_clk),
    .o_wr      (tbl_wr),
    .o_cmd     (cmd)
  );

  // device under test
  ppt_trigger i_dut (
    .i_sys_clk                    (i_sys_clk),
    .i_reset_n                    (i_reset_n),
    .i_tbl_wr                     (tbl_wr),
    .i_cmd                        (cmd),
    .i_width_mode_param           (wm),
    .i_incremental_enc            (inc),
    .i_servo_on                   (servo),
    .i_position                   (pos),
    .o_fast_trig                  (fast),
    .o_norm_trig                  (norm),
    .o_sensor_on                  (sens),
    .o_reference_established_flag (reference_established_flag),
    .o_armed                      (armed)
  );

  // 125 MHz clock
  always #4 i_sys_clk = ~i_sys_clk;

  // verdict and end of run
  task automatic test_done();
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // function word: direction, terminal, axis 0
  function automatic logic [31:0] fn(input logic [3:0] term,
                                     input logic [3:0] dir);
    return {20'h00000, dir, term, 4'h0};
  endfunction : fn

  // expected firing for direction code and travel sense
  function automatic logic fires(input int d, input logic fwd);
    return (d == 2) || (d == 0 && fwd) || (d == 1 && !fwd);
  endfunction : fires

  task automatic mv(input logic [31:0] p);
    @(posedge i_sys_clk);
    pos <= p;
  endtask : mv

  task automatic look(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : look

  // move with the servo off so no crossing is seen
  task automatic rep(input logic [31:0] p);
    @(posedge i_sys_clk);
    servo <= 1'b0;
    pos   <= p;
    @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    servo <= 1'b1;
  endtask : rep

  // one direction trial in distance mode
  task automatic trial(input int d, input logic f);
    i_host.wr(3'h0, ppt_pkg::FLD_FUNC,
              fn(f ? ppt_pkg::FT_T0 : ppt_pkg::FT_T1, d[3:0]));
    i_host.cmd(ppt_pkg::CMD_SETUP_DEV, 1'b0);
    rep(f ? tgt - 32'h1 : tgt + 32'h1);
    mv(tgt);
    look(4);
    chk(fast[f ? 0 : 1], fires(d, f));
    mv(f ? tgt + 32'h14 : tgt - 32'h14);
    look(5);
    chk(fast, 32'h0);
  endtask : trial

  // watchdog
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_total++;
    test_done();
  end

  // main sequence
  initial begin
    i_sys_clk = 1'b0;
    i_reset_n = 1'b0;
    wm        = ppt_pkg::WM_TIME;
    inc       = 1'b1;
    servo     = 1'b0;
    pos       = '0;
    err_total = 0;
    compares  = 0;
    seed      = $urandom(32'hB241);
    p_nom     = 32'h00001000 + ($urandom & 32'h0000FFFF);
    comp      = ($urandom & 32'h000000FF) - 32'h00000080;
    tgt       = p_nom + comp;
    repeat (16) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    look(1);
    chk({fast, norm, sens, reference_established_flag, armed}, 32'h0);
    // sensor on, then reference by zero return and set coordinates
    @(posedge i_sys_clk);
    servo <= 1'b1;
    i_host.cmd(ppt_pkg::CMD_SENSOR_ON, 1'b0);
    look(1);
    chk(sens, 32'h1);
    chk(armed, 32'h0);
    i_host.cmd(ppt_pkg::CMD_ZERO_RET, 1'b0);
    look(1);
    chk(armed, 32'h1);
    i_host.cmd(ppt_pkg::CMD_SET_COORD, 1'b0);
    look(1);
    chk({reference_established_flag, armed}, 32'h0);
    i_host.cmd(ppt_pkg::CMD_SET_COORD, 1'b1);
    look(1);
    chk({reference_established_flag, armed}, 32'h3);
    // uncommitted table must not fire
    i_host.load(3'h0, p_nom, fn(ppt_pkg::FT_T0, ppt_pkg::DIR_FWD),
                32'h3, 32'h8, comp);
    rep(tgt - 32'h1);
    mv(tgt);
    look(4);
    chk(fast, 32'h0);
    // committed: time width of 3 us
    i_host.cmd(ppt_pkg::CMD_SETUP_DEV, 1'b0);
    rep(tgt - 32'h1);
    mv(tgt);
    look(4);
    chk(fast, 32'h1);
    look(196);
    chk(fast, 32'h1);
    look(200);
    chk(fast, 32'h0);
    // every direction code both ways, distance mode
    @(posedge i_sys_clk);
    wm <= ppt_pkg::WM_DIST;
    for (int d = 0; d < 3; d++) begin
      trial(d, 1'b1);
      trial(d, 1'b0);
    end
    // inverted fast entry: idle level comes from entry 0 polarity
    i_host.wr(3'h0, ppt_pkg::FLD_FUNC,
              fn(ppt_pkg::FT_T0_INV, ppt_pkg::DIR_BOTH));
    i_host.cmd(ppt_pkg::CMD_SETUP_DEV, 1'b0);
    look(2);
    chk(fast, 32'h1);
    // photocoupler: inverted entry 4 and plain entry 5 share t0
    @(posedge i_sys_clk);
    wm <= ppt_pkg::WM_TIME;
    i_host.load(3'h4, p_nom, fn(ppt_pkg::NT_INV_BASE, ppt_pkg::DIR_BOTH),
                32'h2, 32'h8, comp);
    i_host.wr(3'h5, ppt_pkg::FLD_FUNC, fn(ppt_pkg::NT_BASE, 4'h2));
    i_host.cmd(ppt_pkg::CMD_SETUP_DEV, 1'b0);
    // terminal register follows the commit one edge later
    look(2);
    chk(norm, 32'h1);
    rep(tgt - 32'h1);
    mv(tgt);
    look(4);
    chk(norm, 32'h0);
    chk(fast, 32'h0);
    look(400);
    chk(norm, 32'h0);
    chk(fast, 32'h1);
    @(posedge i_sys_clk);
    wm  <= ppt_pkg::WM_DIST;
    pos <= tgt + 32'h32;
    look(5);
    chk(norm, 32'h1);
    test_done();
  end
endmodule : ppt_trigger_test
